//--- rtl/mcp_timer.sv
// two-counter capture/compare/pwm timer unit with match-and-clear limits
`timescale 1ns/1ps
module mcp_timer (
    input  wire logic                       i_clock,
    input  wire logic                       i_rst_n,
    input  wire mcp_pkg::mcp_bus_s          i_bus,
    output logic [31:0]                     o_rdata,
    input  wire logic [mcp_pkg::NCH-1:0]    i_capture_input_pin,
    output logic [mcp_pkg::NCH-1:0]         o_timer_output_pin,
    output mcp_pkg::mcp_irq_s               o_irq
);
    import mcp_pkg::*;

    // ------------------------------------------------------------------------
    // state and per-cycle terms
    // ------------------------------------------------------------------------
    mcp_state_s      s_r;
    mcp_state_s      s_nxt;
    logic [NCNT-1:0] tick;       // count clock enable per counter
    logic [NCNT-1:0] evt;        // wrap or match-and-clear of a counter
    logic [NCNT-1:0] sclr;
    logic [NCH-1:0]  rd_ch;
    logic [NCH-1:0]  wr_ch;
    logic [NCH-1:0]  hit;        // assigned counter leaves the compare value
    logic [NCH-1:0]  cap_edge;
    logic [NCH-1:0]  ch_tick;
    logic [NCH-1:0][CW-1:0] sel_cnt;
    logic [NCH-1:0][1:0]    edge_sel;
    logic [NCH-1:0]         alv_all;    // inactive level of every pin

    // ------------------------------------------------------------------------
    // capture front ends
    // ------------------------------------------------------------------------
    for (genvar g = 0; g < NCH; g++) begin : g_cap
        assign ch_tick[g]  = tick[s_r.cfg[g][F_CSEL]];
        assign sel_cnt[g]  = s_r.cnt[s_r.cfg[g][F_CSEL]];
        assign edge_sel[g] = s_r.cfg[g][F_EDGE+:2];
        assign alv_all[g]  = s_r.cfg[g][F_ALV];
        mcp_cap_sync #(
            .STAGES     (CAP_STAGES)
        ) u_cap (
            .i_clock    (i_clock),
            .i_rst_n    (i_rst_n),
            .i_pin      (i_capture_input_pin[g]),
            .i_tick     (ch_tick[g]),
            .i_edge_sel (edge_sel[g]),
            .o_edge     (cap_edge[g])
        );
    end

    // ------------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------------
    // one pass: bus write, counters, start sequencing, channels, pins, read
    always_comb begin
        logic [PRE_W-1:0] mask;
        logic             x;
        logic             go;
        logic             was;
        logic             act;
        logic [31:0]      rd;
        mask  = '0;
        x     = 1'b0;
        go    = 1'b0;
        was   = 1'b0;
        act   = 1'b0;
        rd    = '0;
        s_nxt = s_r;
        s_nxt.irq = '0;
        tick  = '0;
        evt   = '0;
        sclr  = '0;
        hit   = '0;

        // channel address decode
        for (int i = 0; i < NCH; i++) begin
            rd_ch[i] = i_bus.re && (i_bus.addr == OFF_CH0 + ADDR_W'(i) * OFF_CH_STEP);
            wr_ch[i] = i_bus.we && (i_bus.addr == OFF_CH0 + ADDR_W'(i) * OFF_CH_STEP);
            if (wr_ch[i]) begin
                s_nxt.shadow[i] = i_bus.wdata[CW-1:0];
            end
        end

        // register writes; the clear bits act once and are not stored
        if (i_bus.we) begin
            unique case (i_bus.addr)
                OFF_CTRL: begin
                    s_nxt.power   = i_bus.wdata[B_POWER];
                    s_nxt.run     = i_bus.wdata[B_RUN+:NCNT];
                    s_nxt.stagger = i_bus.wdata[B_STAGGER];
                    s_nxt.mode    = i_bus.wdata[B_MODE+:NCNT];
                    sclr          = i_bus.wdata[B_SCLR+:NCNT];
                end
                OFF_LIMIT_A:  s_nxt.limit[0] = i_bus.wdata[CW-1:0];
                OFF_LIMIT_B:  s_nxt.limit[1] = i_bus.wdata[CW-1:0];
                OFF_CH_CFG:   s_nxt.cfg      = i_bus.wdata;
                OFF_PRESCALE: begin
                    s_nxt.psel[0] = i_bus.wdata[0+:PS_W];
                    s_nxt.psel[1] = i_bus.wdata[F_PSEL_B+:PS_W];
                end
                default: ;
            endcase
        end

        // prescaler runs only while the unit is powered
        s_nxt.pre = s_r.power ? s_r.pre + 1'b1 : '0;

        for (int c = 0; c < NCNT; c++) begin
            mask    = PRE_W'((1 << s_r.psel[c]) - 1);
            tick[c] = s_r.running[c] && ((s_r.pre & mask) == mask);
            // software clear zeroes the count but is no wrap event
            if (sclr[c]) begin
                s_nxt.cnt[c] = CNT_ZERO;
            end else if (tick[c]) begin
                if (s_r.mode[c] && s_r.limit[c] == CNT_ZERO) begin
                    s_nxt.cnt[c] = CNT_ZERO;
                end else if (s_r.mode[c] && s_r.limit[c] != CNT_ALL
                             && s_r.cnt[c] == s_r.limit[c]) begin
                    s_nxt.cnt[c]     = CNT_ZERO;
                    s_nxt.irq.lim[c] = 1'b1;
                    evt[c]           = 1'b1;
                end else begin
                    s_nxt.cnt[c] = s_r.cnt[c] + 1'b1;
                    if (s_r.cnt[c] == CNT_ALL) begin
                        s_nxt.irq.ovf[c] = 1'b1;
                        evt[c]           = 1'b1;
                    end
                end
            end
            if (s_r.running[c] && s_r.mode[c] && s_r.limit[c] == CNT_ZERO) begin
                s_nxt.irq.lim[c] = 1'b1;
            end
            // start delay depends on whether power was already on
            go  = s_nxt.power && s_nxt.run[c];
            was = s_r.power && s_r.run[c];
            if (!go) begin
                s_nxt.running[c] = 1'b0;
                s_nxt.dly[c]     = '0;
                s_nxt.cnt[c]     = CNT_ZERO;
            end else if (!was) begin
                s_nxt.dly[c] = s_r.power ? START_LATE_CYC : START_EARLY_CYC;
            end else if (s_r.dly[c] != '0) begin
                s_nxt.dly[c] = s_r.dly[c] - 1'b1;
                if (s_r.dly[c] == 4'h1) begin
                    s_nxt.running[c] = 1'b1;
                end
            end
        end

        for (int i = 0; i < NCH; i++) begin
            x      = s_r.cfg[i][F_CSEL];
            hit[i] = tick[x] && (s_r.cnt[x] == s_r.active[i]);
            if (evt[x]) begin
                s_nxt.seen[i] = 1'b1;
            end
            if (!s_r.cfg[i][F_CAPCMP]) begin
                // a read of the channel cancels a capture in the same cycle
                if (cap_edge[i] && !rd_ch[i]) begin
                    s_nxt.shadow[i] = sel_cnt[i];
                    s_nxt.irq.ch[i] = 1'b1;
                    s_nxt.snap[i]   = s_r.seen[i] | evt[x];
                    s_nxt.seen[i]   = 1'b0;
                end
            end else begin
                if (hit[i]) begin
                    s_nxt.irq.ch[i] = 1'b1;
                end
                // compare value is double buffered against mid-period glitches
                if (evt[x] || !s_r.running[x]) begin
                    s_nxt.active[i] = s_nxt.shadow[i];
                end
            end
            // pwm level: 1 = active
            if (tick[x] && s_r.reon[i]) begin
                s_nxt.reon[i] = 1'b0;
                s_nxt.lvl[i]  = 1'b1;
            end
            if (evt[x]) begin
                s_nxt.started[i] = 1'b1;
                if (s_r.started[i] && hit[i]) begin
                    s_nxt.lvl[i]  = 1'b0;
                    s_nxt.reon[i] = 1'b1;
                end else begin
                    s_nxt.lvl[i]  = 1'b1;
                end
            end else if (hit[i]) begin
                s_nxt.lvl[i] = 1'b0;
            end
            if (!s_r.running[x] || !s_r.cfg[i][F_CAPCMP]
                || s_r.active[i] == CNT_ZERO) begin
                s_nxt.lvl[i]     = 1'b0;
                s_nxt.reon[i]    = 1'b0;
                s_nxt.started[i] = s_r.running[x] & s_nxt.started[i];
            end
            // stagger: channel i waits i+1 clocks so no two switch together
            s_nxt.stg[i] = {s_r.stg[i][2:0], s_r.lvl[i]};
            act = s_r.stagger ? s_r.stg[i][i] : s_r.lvl[i];
            act = act && s_r.power && s_r.cfg[i][F_OEN];
            s_nxt.out[i] = act ^ s_r.cfg[i][F_ALV];
            // wrap flag is refreshed only when the channel is read
            if (rd_ch[i]) begin
                s_nxt.wrap[i] = s_r.snap[i];
                rd[CW-1:0]    = s_r.shadow[i];
            end
        end

        // read data, one cycle after the strobe and only then
        if (i_bus.re) begin
            unique case (i_bus.addr)
                OFF_CTRL: begin
                    rd[B_POWER]       = s_r.power;
                    rd[B_RUN+:NCNT]   = s_r.run;
                    rd[B_STAGGER]     = s_r.stagger;
                    rd[B_MODE+:NCNT]  = s_r.mode;
                end
                OFF_LIMIT_A:  rd[CW-1:0] = s_r.limit[0];
                OFF_LIMIT_B:  rd[CW-1:0] = s_r.limit[1];
                OFF_CH_CFG:   rd         = s_r.cfg;
                OFF_STATUS: begin
                    rd[F_WRAP+:NCH]     = s_r.wrap;
                    rd[F_RUNNING+:NCNT] = s_r.running;
                end
                OFF_CNT_A:    rd[CW-1:0] = s_r.cnt[0];
                OFF_CNT_B:    rd[CW-1:0] = s_r.cnt[1];
                OFF_PRESCALE: begin
                    rd[0+:PS_W]        = s_r.psel[0];
                    rd[F_PSEL_B+:PS_W] = s_r.psel[1];
                end
                default: ;
            endcase
        end
        s_nxt.rdata = rd;
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_r <= RST_STATE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_rdata            = s_r.rdata;
    assign o_timer_output_pin = s_r.out;
    assign o_irq              = s_r.irq;

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    logic alv0;
    logic ctrl_wr;
    assign alv0    = s_r.cfg[0][F_ALV];
    assign ctrl_wr = i_bus.we && i_bus.addr == OFF_CTRL;

    property p_cap_latch;
        (cap_edge[0] && !s_r.cfg[0][F_CAPCMP] && !rd_ch[0] && !ctrl_wr)
            |=> (s_r.irq.ch[0] && s_r.shadow[0] == $past(sel_cnt[0]));
    endproperty
    a_cap_latch: assert property (p_cap_latch)
        else $error("capture did not latch count");

    property p_limit_clear;
        (tick[0] && s_r.mode[0] && s_r.limit[0] != CNT_ZERO
         && s_r.limit[0] != CNT_ALL && s_r.cnt[0] == s_r.limit[0] && !ctrl_wr)
            |=> (s_r.irq.lim[0] && s_r.cnt[0] == CNT_ZERO);
    endproperty
    a_limit_clear: assert property (p_limit_clear)
        else $error("match and clear missed");

    property p_limit_zero;
        (s_r.running[0] && s_r.mode[0] && s_r.limit[0] == CNT_ZERO && !ctrl_wr)
            |=> (s_r.cnt[0] == CNT_ZERO && s_r.irq.lim[0]) [*2];
    endproperty
    a_limit_zero: assert property (p_limit_zero)
        else $error("zero limit did not hold counter");

    property p_limit_ffff;
        (s_r.mode[0] && s_r.limit[0] == CNT_ALL) |=> !s_r.irq.lim[0];
    endproperty
    a_limit_ffff: assert property (p_limit_ffff)
        else $error("limit irq with ffffh limit");

    property p_cmp_hit;
        (hit[0] && s_r.cfg[0][F_CAPCMP]) |=> s_r.irq.ch[0];
    endproperty
    a_cmp_hit: assert property (p_cmp_hit)
        else $error("compare match irq missing");

    property p_pwm_zero;
        (s_r.active[0] == CNT_ZERO) |=> !s_r.lvl[0] ##1 (s_r.out[0] == $past(alv0));
    endproperty
    a_pwm_zero: assert property (p_pwm_zero)
        else $error("pwm active with zero compare");

    property p_power_off;
        !s_r.power |=> (s_r.out == $past(alv_all));
    endproperty
    a_power_off: assert property (p_power_off)
        else $error("pin active while unpowered");

    property p_start_late;
        (ctrl_wr && i_bus.wdata[B_POWER] && i_bus.wdata[B_RUN] && s_r.power
         && !s_r.run[0])
            |=> (!s_r.running[0] && s_r.power) [*8] ##1 s_r.running[0];
    endproperty
    a_start_late: assert property (p_start_late)
        else $error("late start not eight clocks");

    property p_wrap_read;
        rd_ch[0] |=> (s_r.wrap[0] == $past(s_r.snap[0]));
    endproperty
    a_wrap_read: assert property (p_wrap_read)
        else $error("wrap flag not refreshed on read");

    c_capture: cover property (cap_edge[0] ##1 s_r.irq.ch[0]);
    c_clear:   cover property (s_r.irq.lim[0] ##1 !s_r.irq.lim[0]);
    c_pwm:     cover property (s_r.started[0] && $rose(s_r.lvl[0]));
endmodule : mcp_timer

//--- rtl/mcp_pkg.sv
// constants, field layouts and carrier types of the match-and-clear timer unit
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package mcp_pkg;
    localparam int NCH    = 4;
    localparam int NCNT   = 2;
    localparam int CW     = 16;
    localparam int ADDR_W = 8;
    localparam int DLY_W  = 4;
    localparam int PRE_W  = 8;
    localparam int PS_W   = 3;

    // register offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_LIMIT_A  = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_LIMIT_B  = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_CH_CFG   = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_CH0      = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_CH_STEP  = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_CNT_A    = 8'h24;
    localparam logic [ADDR_W-1:0] OFF_CNT_B    = 8'h28;
    localparam logic [ADDR_W-1:0] OFF_PRESCALE = 8'h2c;

    // control register bits
    localparam int B_POWER   = 0;
    localparam int B_RUN     = 1;   // two bits: counter a, counter b
    localparam int B_STAGGER = 3;
    localparam int B_MODE    = 4;   // two bits: 1 = match and clear
    localparam int B_SCLR    = 6;   // two bits, write one to clear, read zero
    // channel config, one byte per channel
    localparam int CFG_STEP  = 8;
    localparam int F_CAPCMP  = 0;   // 1 = compare, 0 = capture
    localparam int F_CSEL    = 1;   // 0 = counter a, 1 = counter b
    localparam int F_ALV     = 2;   // 1 = active low
    localparam int F_OEN     = 3;
    localparam int F_EDGE    = 4;   // two bits
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    // status and prescale fields
    localparam int F_WRAP    = 0;
    localparam int F_RUNNING = 4;
    localparam int F_PSEL_B  = 4;

    // values and timing counts
    localparam logic [CW-1:0]    CNT_ZERO        = 16'h0000;
    localparam logic [CW-1:0]    CNT_ALL         = 16'hffff;
    localparam logic [DLY_W-1:0] START_EARLY_CYC = 4'he;
    localparam logic [DLY_W-1:0] START_LATE_CYC  = 4'h8;
    localparam int               CAP_STAGES      = 4;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
        logic              we;
        logic              re;
    } mcp_bus_s;

    typedef struct packed {
        logic [NCH-1:0]  ch;
        logic [NCNT-1:0] lim;
        logic [NCNT-1:0] ovf;
    } mcp_irq_s;

    typedef struct packed {
        logic                      power;
        logic                      stagger;
        logic [NCNT-1:0]           run;
        logic [NCNT-1:0]           mode;
        logic [NCNT-1:0][PS_W-1:0] psel;
        logic [NCNT-1:0][CW-1:0]   limit;
        logic [NCH-1:0][7:0]       cfg;
        logic [NCH-1:0][CW-1:0]    shadow;
        logic [NCH-1:0][CW-1:0]    active;
        logic [NCNT-1:0][CW-1:0]   cnt;
        logic [NCNT-1:0]           running;
        logic [NCNT-1:0][DLY_W-1:0] dly;
        logic [PRE_W-1:0]          pre;
        logic [NCH-1:0]            seen;
        logic [NCH-1:0]            snap;
        logic [NCH-1:0]            wrap;
        logic [NCH-1:0]            started;
        logic [NCH-1:0]            lvl;
        logic [NCH-1:0]            reon;
        logic [NCH-1:0][3:0]       stg;
        logic [NCH-1:0]            out;
        mcp_irq_s                  irq;
        logic [31:0]               rdata;
    } mcp_state_s;

    localparam mcp_state_s RST_STATE = '0;
endpackage : mcp_pkg

//--- rtl/mcp_cap_sync.sv
// capture pin synchroniser and count-clock edge detector for one channel
`timescale 1ns/1ps
module mcp_cap_sync #(
    parameter int STAGES = mcp_pkg::CAP_STAGES
) (
    input  wire logic       i_clock,
    input  wire logic       i_rst_n,
    input  wire logic       i_pin,
    input  wire logic       i_tick,
    input  wire logic [1:0] i_edge_sel,
    output logic            o_edge
);
    import mcp_pkg::*;

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [1:0]        sync;
        logic [STAGES-1:0] smp;
    } mcp_cs_s;

    mcp_cs_s s_r;
    mcp_cs_s s_nxt;
    logic    now_lvl;
    logic    old_lvl;

    if (STAGES < 3) begin : g_bad_stages
        $error("mcp_cap_sync needs at least three sample stages");
    end

    // two flops against metastability, then samples taken on count ticks only
    always_comb begin
        s_nxt      = s_r;
        s_nxt.sync = {s_r.sync[0], i_pin};
        if (i_tick) begin
            s_nxt.smp = {s_r.smp[STAGES-2:0], s_r.sync[1]};
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // the edge is seen between the last two stages: the pipeline depth sets
    // the latency of three to four count periods
    assign now_lvl = s_r.smp[STAGES-2];
    assign old_lvl = s_r.smp[STAGES-1];
    assign o_edge  = i_tick & ((i_edge_sel[0] & now_lvl & ~old_lvl)
                             | (i_edge_sel[1] & ~now_lvl & old_lvl));
endmodule : mcp_cap_sync

//--- verif/mcp_far_end.sv
// far-side model: capture trigger source and the load on pwm pin 0
`timescale 1ns/1ps
module mcp_far_end (
    input  wire logic       i_clock,
    input  wire logic [3:0] i_fire,
    input  wire logic [3:0] i_pwm_pin,
    output logic [3:0]      o_cap_pin,
    output int              o_active_cnt
);
    // trigger lines are driven at all times, so they never float
    initial o_cap_pin = 4'h0;
    initial o_active_cnt = 0;
    // toggle a trigger on request; the load counts cycles with pin 0 high
    always @(posedge i_clock) begin
        o_cap_pin    <= o_cap_pin ^ i_fire;
        o_active_cnt <= o_active_cnt + int'(i_pwm_pin[0]);
    end
endmodule : mcp_far_end

//--- verif/mcp_timer_tb.sv
// self-checking bench of the match-and-clear timer unit
`timescale 1ns/1ps
module mcp_timer_tb;
    import mcp_pkg::*;
    typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} mcp_row_s;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    mcp_bus_s    bus   = '0;
    logic [3:0]  fire  = 4'h0;
    logic [31:0] rdata, got;
    logic [3:0]  cap_pin, pwm_pin;
    mcp_irq_s    irq;
    int          act_cnt, num_errors = 0, check_count = 0, n, m, k;
    // upper half of a word is dropped; the software clear reads zero
    mcp_row_s    rows [5] = '{'{OFF_LIMIT_A, 32'habcd1234, 32'h00001234},
        '{OFF_LIMIT_B, 32'h0000ffff, 32'h0000ffff}, '{OFF_CH0, 32'h00000055, 32'h00000055},
        '{8'h3c, 32'h00005a5a, 32'h00000000}, '{OFF_CTRL, 32'h000000c0, 32'h00000000}};

    always #5 clock = ~clock;

    mcp_timer u_mcp_timer (.i_clock(clock), .i_rst_n(rst_n), .i_bus(bus), .o_rdata(rdata),
        .i_capture_input_pin(cap_pin), .o_timer_output_pin(pwm_pin), .o_irq(irq));
    mcp_far_end u_mcp_far_end (.i_clock(clock), .i_fire(fire), .i_pwm_pin(pwm_pin),
        .o_cap_pin(cap_pin), .o_active_cnt(act_cnt));

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // each access starts on an edge, so strobes are never assigned twice at once
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        bus.addr  <= a;
        bus.wdata <= d;
        bus.we    <= 1'b1;
        @(posedge clock);
        bus.we    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        bus.addr <= a;
        bus.re   <= 1'b1;
        @(posedge clock);
        bus.re   <= 1'b0;
        #1 d = rdata;
    endtask : rd
    // settle past the edge before any look at outputs
    task automatic tick(input int c);
        repeat (c) @(posedge clock);
        #1;
    endtask : tick
    task automatic finish_test;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------------
    // watchdog, far above the few hundred cycles the tests need
    // ------------------------------------------------------------------
    initial begin
        repeat (5000) @(posedge clock);
        num_errors++;
        finish_test();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        tick(1);
        check("reset pins", 32'h0, {28'h0, pwm_pin});
        check("reset irq", 32'h0, {24'h0, irq});
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, got);
            check("register read", rows[i].e, got);
        end
        // limit of zero: counter pinned at zero, limit irq held
        wr(OFF_LIMIT_A, 32'h0);
        wr(OFF_CTRL, 32'h13);
        tick(30);
        check("limit irq held", 32'h1, {31'h0, irq.lim[0]});
        rd(OFF_CNT_A, got);
        check("pinned count", 32'h0, got);
        wr(OFF_CTRL, 32'h0);
        // limit 3, ch0 compare 1 driving pwm, ch1 captures rising edges
        wr(OFF_LIMIT_A, 32'h3);
        wr(OFF_CH_CFG, 32'h1009);
        wr(OFF_CH0, 32'h1);
        wr(OFF_CTRL, 32'h13);
        tick(40);
        n = 0;
        m = 0;
        k = act_cnt;
        repeat (40) begin
            tick(1);
            n += int'(irq.lim[0]);
            m += int'(irq.ch[0]);
        end
        check("limit pulses", 32'd10, n);
        check("match pulses", 32'd10, m);
        check("active cycles", 32'd20, act_cnt - k);
        // rewrite while running, then keep away from the channel long enough
        wr(OFF_CH0, 32'h2);
        tick(16);
        k = act_cnt;
        tick(40);
        check("new compare width", 32'd30, act_cnt - k);
        // a trigger edge; the irq must follow within a few count ticks
        @(posedge clock);
        fire <= 4'h2;
        @(posedge clock);
        fire <= 4'h0;
        n = 0;
        while (irq.ch[1] !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        check("capture delay ok", 32'h1, {31'h0, n >= 5 && n <= 9});
        rd(OFF_CH0 + OFF_CH_STEP, got);
        check("captured below limit", 32'h0, {got[31:2], 2'h0});
        // power off with run still set forces pins inactive
        wr(OFF_CTRL, 32'h12);
        tick(6);
        check("pins unpowered", 32'h0, {28'h0, pwm_pin});
        // run set after power: running shows up eight clocks after the write
        wr(OFF_CTRL, 32'h01);
        wr(OFF_CTRL, 32'h13);
        tick(6);
        rd(OFF_STATUS, got);
        check("late start not yet", 32'h0, {31'h0, got[F_RUNNING]});
        rd(OFF_STATUS, got);
        check("late start running", 32'h1, {31'h0, got[F_RUNNING]});
        check("wrap flag after clears", 32'h1, {31'h0, got[F_WRAP+1]});
        finish_test();
    end
endmodule : mcp_timer_tb
